// ==== fcs_pkg.sv ====
// constants, states and carriers for the flash command sequencer
package fcs_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_PROG_US = 40;
    localparam int T_ERASE_MS = 30;
    // longest times round down to whole cycles
    localparam int PROG_CYC = (T_PROG_US * 1000) / CLK_PERIOD_NS;
    localparam int ERASE_CYC = (T_ERASE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CNT_W = 19;

    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_SECT = 8'h30;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam logic [7:0] CMD_SECURE = 8'hA5;
    localparam logic [7:0] SECURE_DATA = 8'h00;
    localparam logic [7:0] APPLY_KEY = 8'hD5;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] SECURED_BYTE = 8'h00;

    localparam logic [11:0] OFS_FIRST = 12'h555;
    localparam logic [11:0] OFS_SECOND = 12'hAAA;
    localparam logic [15:0] ADDR_SECURE = 16'hFF7F;
    localparam logic [15:0] ADDR_VENDOR = 16'hF000;
    localparam logic [15:0] ADDR_FLASH_ID = 16'hF001;

    localparam logic [2:0] WP_ENABLE = 3'b101;
    localparam logic [2:0] WP_RESET = 3'b010;
    localparam int TOGGLE_POS = 6;
    localparam logic FLASH_STANDBY_BIT_RESET = 1'b0;

    typedef enum logic [8:0] {
        ST_IDLE = 9'b0_0000_0001,
        ST_UNL1 = 9'b0_0000_0010,
        ST_UNL2 = 9'b0_0000_0100,
        ST_ERS3 = 9'b0_0000_1000,
        ST_ERS4 = 9'b0_0001_0000,
        ST_ERS5 = 9'b0_0010_0000,
        ST_PDAT = 9'b0_0100_0000,
        ST_SECR = 9'b0_1000_0000,
        ST_BUSY = 9'b1_0000_0000
    } fcs_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] data;
    } fcs_req_s;

    typedef struct packed {
        logic prog;
        logic sect_erase;
        logic chip_erase;
        logic secure;
        logic [15:0] addr;
        logic [7:0] data;
    } fcs_arr_s;
endpackage

// ==== fcs_top.sv ====
// flash command sequencer: standby bit, port input gating, command decode and toggle polling
`timescale 1ns/1ns
module fcs_top
    import fcs_pkg::*;
#(
    parameter int P_ERASE_CYC = ERASE_CYC,
    parameter logic [7:0] P_VENDOR_ID = 8'h5A,  // arbitrary value
    parameter logic [7:0] P_FLASH_ID = 8'h3C    // arbitrary value
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire fcs_req_s i_req,
    input wire logic [7:0] i_arr_rdata,
    input wire logic i_exec_from_ram,
    input wire logic i_flash_standby_bit_wr,
    input wire logic i_flash_standby_bit_wdata,
    input wire logic i_irq_take,
    input wire logic i_vector_ram,
    input wire logic i_serial_prom,
    input wire logic i_parallel_prom,
    input wire logic i_port_ctl_wr,
    input wire logic [1:0] i_port_ctl_wdata,
    input wire logic i_ctl1_wr,
    input wire logic [2:0] i_ctl1_mode,
    input wire logic i_ctl2_wr,
    input wire logic [7:0] i_ctl2_data,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_busy,
    output logic o_id_mode,
    output logic o_secured,
    output logic o_flash_standby_bit,
    output logic o_standby_rst,
    output logic o_port_in_en,
    output logic o_sclk_in_en,
    output fcs_arr_s o_arr
);
    fcs_state_e st_q;
    logic flash_standby_bit_q;
    logic other_ports_input_enable_q;
    logic serial_clock_input_enable_q;
    logic [2:0] mode_stage_q;
    logic [2:0] mode_eff_q;
    logic [CNT_W-1:0] cnt_q;
    logic toggle_q;
    logic id_mode_q;
    logic secured_q;
    logic op_chip_q;
    logic op_secure_q;
    logic first_rd_q;
    logic wp_en;
    logic flash_hit;
    logic irq_clr;
    logic w;
    logic rd;
    logic a_first;
    logic a_second;
    logic start_prog;
    logic start_sect;
    logic start_chip;
    logic start_sec;
    logic start_any;
    logic [CNT_W-1:0] load_cnt;

    assign wp_en = (mode_eff_q == WP_ENABLE);
    // the flash array answers at 0x8000 and above, whatever the upper nibble
    assign flash_hit = i_req.valid && i_req.addr[15];
    assign irq_clr = i_irq_take && !i_vector_ram;
    assign w = flash_hit && i_req.write && !flash_standby_bit_q && wp_en;
    assign rd = flash_hit && !i_req.write && !flash_standby_bit_q;
    assign a_first = (i_req.addr[11:0] == OFS_FIRST);
    assign a_second = (i_req.addr[11:0] == OFS_SECOND);

    always_comb begin
        start_prog = w && (st_q == ST_PDAT);
        start_sect = w && (st_q == ST_ERS5) && (i_req.data == CMD_SECT) && !i_parallel_prom;
        start_chip = w && (st_q == ST_ERS5) && (i_req.data == CMD_CHIP) && a_first;
        start_sec = w && (st_q == ST_SECR) && (i_req.addr == ADDR_SECURE) && (i_req.data == SECURE_DATA);
        start_any = start_prog || start_sect || start_chip || start_sec;
        if (start_sect || start_chip) begin
            load_cnt = CNT_W'(P_ERASE_CYC - 1);
        end else begin
            load_cnt = CNT_W'(PROG_CYC - 1);
        end
    end

    // interrupt clear wins over a write in the same cycle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flash_standby_bit_q <= FLASH_STANDBY_BIT_RESET;
        end else if (irq_clr) begin
            flash_standby_bit_q <= 1'b0;
        end else if (i_flash_standby_bit_wr && i_exec_from_ram) begin
            flash_standby_bit_q <= i_flash_standby_bit_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_standby_rst <= 1'b0;
        end else begin
            o_standby_rst <= flash_hit && flash_standby_bit_q && !irq_clr;
        end
    end

    // control bits only take writes in serial PROM mode
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            other_ports_input_enable_q <= 1'b0;
            serial_clock_input_enable_q <= 1'b0;
        end else if (i_port_ctl_wr && i_serial_prom) begin
            other_ports_input_enable_q <= i_port_ctl_wdata[0];
            serial_clock_input_enable_q <= i_port_ctl_wdata[1];
        end
    end

    // gating follows the enable bits only in serial PROM mode
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_port_in_en <= 1'b0;
            o_sclk_in_en <= 1'b0;
        end else begin
            o_port_in_en <= !i_serial_prom || other_ports_input_enable_q;
            o_sclk_in_en <= !i_serial_prom || serial_clock_input_enable_q;
        end
    end

    // mode field only takes effect on the apply key
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_stage_q <= WP_RESET;
            mode_eff_q <= WP_RESET;
        end else begin
            if (i_ctl1_wr) begin
                mode_stage_q <= i_ctl1_mode;
            end
            if (i_ctl2_wr && (i_ctl2_data == APPLY_KEY)) begin
                mode_eff_q <= mode_stage_q;
            end
        end
    end

    // sequence decoder; a wrong cycle drops back to idle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_IDLE;
            o_busy <= 1'b0;
            cnt_q <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (w && a_first && (i_req.data == CMD_UNLOCK1)) begin
                        st_q <= ST_UNL1;
                    end
                end
                ST_UNL1: begin
                    if (w) begin
                        st_q <= (a_second && i_req.data == CMD_UNLOCK2) ? ST_UNL2 : ST_IDLE;
                    end
                end
                ST_UNL2: begin
                    if (w) begin
                        if (!a_first) begin
                            st_q <= ST_IDLE;
                        end else if (i_req.data == CMD_PROG) begin
                            st_q <= ST_PDAT;
                        end else if (i_req.data == CMD_ERASE) begin
                            st_q <= ST_ERS3;
                        end else if (i_req.data == CMD_SECURE) begin
                            st_q <= ST_SECR;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_ERS3: begin
                    if (w) begin
                        st_q <= (a_first && i_req.data == CMD_UNLOCK1) ? ST_ERS4 : ST_IDLE;
                    end
                end
                ST_ERS4: begin
                    if (w) begin
                        st_q <= (a_second && i_req.data == CMD_UNLOCK2) ? ST_ERS5 : ST_IDLE;
                    end
                end
                ST_ERS5, ST_PDAT, ST_SECR: begin
                    if (start_any) begin
                        st_q <= ST_BUSY;
                        o_busy <= 1'b1;
                        cnt_q <= load_cnt;
                    end else if (w) begin
                        st_q <= ST_IDLE;
                    end
                end
                // writes are ignored until the count runs out
                ST_BUSY: begin
                    if (cnt_q == '0) begin
                        st_q <= ST_IDLE;
                        o_busy <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // one-cycle command to the array macro
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arr <= '0;
        end else begin
            o_arr.prog <= start_prog;
            o_arr.sect_erase <= start_sect;
            o_arr.chip_erase <= start_chip;
            o_arr.secure <= start_sec;
            if (start_any) begin
                o_arr.addr <= i_req.addr;
                o_arr.data <= start_prog ? i_req.data : ERASED_BYTE;
            end
        end
    end

    // security flag: set by a finished security program, cleared by a finished chip erase
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op_chip_q <= 1'b0;
            op_secure_q <= 1'b0;
            secured_q <= 1'b0;
        end else if (start_any) begin
            op_chip_q <= start_chip;
            op_secure_q <= start_sec;
        end else if (st_q == ST_BUSY && cnt_q == '0) begin
            if (op_secure_q) begin
                secured_q <= 1'b1;
            end else if (op_chip_q) begin
                secured_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            id_mode_q <= 1'b0;
        end else if (w && st_q == ST_UNL2 && a_first && i_req.data == CMD_ID_ENTRY) begin
            id_mode_q <= 1'b1;
        end else if (w && st_q == ST_IDLE && i_req.data == CMD_ID_EXIT) begin
            id_mode_q <= 1'b0;
        end
    end

    // toggle starts at one and flips on every busy read
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            toggle_q <= 1'b1;
        end else if (start_any) begin
            toggle_q <= 1'b1;
        end else if (rd && o_busy && wp_en) begin
            toggle_q <= !toggle_q;
        end
    end

    // marks the first status read of each operation, so the first-read check needs no back-to-back reads
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            first_rd_q <= 1'b0;
        end else if (start_any) begin
            first_rd_q <= 1'b1;
        end else if (rd && o_busy && wp_en) begin
            first_rd_q <= 1'b0;
        end
    end

    // read answer one cycle after the request
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= rd;
            if (rd) begin
                if (o_busy && wp_en) begin
                    o_rdata <= i_arr_rdata;
                    o_rdata[TOGGLE_POS] <= toggle_q;
                end else if (id_mode_q && i_req.addr == ADDR_VENDOR) begin
                    o_rdata <= P_VENDOR_ID;
                end else if (id_mode_q && i_req.addr == ADDR_FLASH_ID) begin
                    o_rdata <= P_FLASH_ID;
                end else if (id_mode_q && i_req.addr == ADDR_SECURE) begin
                    o_rdata <= secured_q ? SECURED_BYTE : ERASED_BYTE;
                end else begin
                    o_rdata <= i_arr_rdata;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_id_mode <= 1'b0;
            o_secured <= 1'b0;
            o_flash_standby_bit <= FLASH_STANDBY_BIT_RESET;
        end else begin
            o_id_mode <= id_mode_q;
            o_secured <= secured_q;
            o_flash_standby_bit <= flash_standby_bit_q;
        end
    end

    chk_flash_standby_bit_ram_only: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        $changed(flash_standby_bit_q) |-> $past(irq_clr) || $past(i_flash_standby_bit_wr && i_exec_from_ram))
        else $error("standby bit changed without a RAM write");
    chk_standby_reset: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        flash_hit && flash_standby_bit_q && !irq_clr |=> o_standby_rst)
        else $error("flash access in standby gave no reset");
    chk_irq_clears: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        irq_clr |=> !flash_standby_bit_q ##1 !o_flash_standby_bit)
        else $error("flash vector interrupt left standby set");
    chk_irq_keeps: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_irq_take && i_vector_ram && !i_flash_standby_bit_wr |=> $stable(flash_standby_bit_q))
        else $error("RAM vector interrupt changed standby bit");
    chk_serial_gate: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_serial_prom && !other_ports_input_enable_q |=> !o_port_in_en)
        else $error("port inputs open in serial mode");
    chk_mcu_open: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !i_serial_prom |=> o_port_in_en && o_sclk_in_en)
        else $error("port inputs gated in MCU mode");
    chk_prog_cmd: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        start_prog |=> o_arr.prog && o_arr.addr == $past(i_req.addr) && o_arr.data == $past(i_req.data))
        else $error("byte program not issued");
    chk_prog_busy: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        start_prog |=> o_busy ##[399:399] o_busy ##1 !o_busy)
        else $error("program busy length wrong");
    chk_toggle_flip: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        rd && o_busy && wp_en |=> o_rdata[TOGGLE_POS] == $past(toggle_q) && toggle_q != $past(toggle_q))
        else $error("status toggle bit did not flip");
    chk_sector_pick: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        start_sect |=> o_arr.sect_erase && o_arr.addr[15:12] == $past(i_req.addr[15:12]))
        else $error("sector erase address wrong");
    chk_no_par_sect: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_parallel_prom |=> !o_arr.sect_erase)
        else $error("sector erase in parallel mode");
    chk_locked: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !wp_en && st_q == ST_IDLE |=> st_q == ST_IDLE)
        else $error("sequence advanced while protected");
    chk_first_toggle: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        first_rd_q && rd && o_busy && wp_en |=> o_rdata[TOGGLE_POS])
        else $error("first toggle read not one");
    chk_id_exit: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        w && st_q == ST_IDLE && i_req.data == CMD_ID_EXIT |=> !id_mode_q ##1 !o_id_mode)
        else $error("exit code left ID mode on");
endmodule

// ==== fcs_flash_array.sv ====
// flash array model behind the sequencer: combinational reads, program and erase on command pulses
`timescale 1ns/1ns
module fcs_flash_array
    import fcs_pkg::*;
(
    input wire logic i_clock,
    input wire fcs_arr_s i_arr,
    input wire logic [15:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:65535];

    // address-dependent contents, so an unerased byte reads as erased only where its two address bytes XOR to FF
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8);
        end
    end

    assign o_rdata = mem[i_raddr];

    always @(posedge i_clock) begin
        if (i_arr.prog) begin
            mem[i_arr.addr] <= i_arr.data;
        end
        if (i_arr.sect_erase) begin
            for (int a = 0; a < 4096; a++) begin
                mem[{i_arr.addr[15:12], 12'(a)}] <= ERASED_BYTE;
            end
        end
        if (i_arr.chip_erase) begin
            for (int a = 0; a < 32768; a++) begin
                mem[{1'b1, 15'(a)}] <= ERASED_BYTE;
            end
        end
    end
endmodule

// ==== tb.sv ====
// self-checking testbench for the flash command sequencer
`timescale 1ns/1ns
module tb
    import fcs_pkg::*;
;
    localparam int ERASE_SIM = 50;
    localparam logic [7:0] VID = 8'h71;  // arbitrary value
    localparam logic [7:0] FID = 8'h2e;  // arbitrary value
    logic i_clock, i_rst_n, ram, fwr, fwd, irq, vram, sprom, pprom, pwr, c1wr, c2wr;
    logic rvalid, busy, idm, sec, flash_standby_bit, srst, pen, sen, rv, sr;
    logic [1:0] pdat;
    logic [2:0] c1m;
    logic [7:0] c2d, ardata, rdata, rd_v;
    fcs_req_s req;
    fcs_arr_s arr;
    int n_fail, compares;
    time t0;

    fcs_top #(.P_ERASE_CYC(ERASE_SIM), .P_VENDOR_ID(VID), .P_FLASH_ID(FID)) dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req), .i_arr_rdata(ardata),
        .i_exec_from_ram(ram), .i_flash_standby_bit_wr(fwr), .i_flash_standby_bit_wdata(fwd), .i_irq_take(irq),
        .i_vector_ram(vram), .i_serial_prom(sprom), .i_parallel_prom(pprom),
        .i_port_ctl_wr(pwr), .i_port_ctl_wdata(pdat), .i_ctl1_wr(c1wr), .i_ctl1_mode(c1m),
        .i_ctl2_wr(c2wr), .i_ctl2_data(c2d), .o_rdata(rdata), .o_rvalid(rvalid), .o_busy(busy),
        .o_id_mode(idm), .o_secured(sec), .o_flash_standby_bit(flash_standby_bit), .o_standby_rst(srst),
        .o_port_in_en(pen), .o_sclk_in_en(sen), .o_arr(arr));

    fcs_flash_array mem_model (.i_clock(i_clock), .i_arr(arr), .i_raddr(req.addr), .o_rdata(ardata));

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic tick;
        @(posedge i_clock);
        #1;
    endtask

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic rst;
        i_rst_n = 1'b0;
        repeat (6) tick;
        i_rst_n = 1'b1;
        tick;
    endtask

    // one-cycle request, released just after the edge that takes it
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        tick;
        req = '{1'b1, w, a, d};
        tick;
        req.valid = 1'b0;
        rv = rvalid;
        sr = srst;
        rd_v = rdata;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(8'(rv), 8'h01);
        chk(rd_v, exp);
    endtask

    task automatic unl(input logic [3:0] n);
        wr({n, 12'h555}, CMD_UNLOCK1);
        wr({n, 12'haaa}, CMD_UNLOCK2);
    endtask

    task automatic cmd(input logic [7:0] c);
        unl(4'hf);
        wr(16'hf555, c);
    endtask

    task automatic pulse(input int k, input logic [1:0] v);
        tick;
        case (k)
            0: {fwr, fwd} = {1'b1, v[0]};
            1: {irq, vram} = {1'b1, v[0]};
            default: {pwr, pdat} = {1'b1, v};
        endcase
        tick;
        {fwr, irq, pwr} = 3'b000;
        tick;
    endtask

    // busy must last exactly the stated count from t0, bounded so a stuck flag ends the run
    task automatic idle(input int exp);
        int n;
        n = 0;
        while (busy === 1'b1 && n < exp + 20) begin
            tick;
            n++;
        end
        compares++;
        if (busy !== 1'b0 || ($time - t0) / 100 != exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, ($time - t0) / 100, exp);
            if (busy !== 1'b0) begin
                conclude;
            end
        end
    endtask

    initial begin
        {i_rst_n, ram, fwr, fwd, irq, vram, sprom, pprom, pwr, c1wr, c2wr} = '0;
        {pdat, c1m, c2d} = '0;
        req = '0;
        n_fail = 0;
        compares = 0;
        rst;
        pulse(2, 2'b00);
        chk(8'({pen, sen}), 8'h03); // mcu ignores control
        cmd(CMD_PROG); // refused while protected
        wr(16'h8001, 8'h00);
        chk(8'(busy), 8'h00); // nothing starts
        done("protect");
        tick;
        c1wr = 1'b1;
        c1m = WP_ENABLE;
        tick;
        c1wr = 1'b0;
        c2wr = 1'b1;
        c2d = APPLY_KEY;
        tick;
        c2wr = 1'b0;
        pprom = 1'b1;
        cmd(CMD_ERASE); // parallel mode refuses sector erase
        unl(4'hf);
        wr(16'hd000, CMD_SECT);
        chk(8'(busy), 8'h00); // no erase started
        pprom = 1'b0;
        rdc(16'hd000, 8'hd0); // sector intact
        rdc(16'h8001, 8'h81); // protected write lost
        done("parallel");
        cmd(CMD_ERASE); // sector erase at e123
        unl(4'hf);
        wr(16'he123, CMD_SECT);
        t0 = $time;
        chk(8'(busy), 8'h01); // busy at once
        idle(ERASE_SIM); // erase time
        rdc(16'he500, ERASED_BYTE); // sector erased
        rdc(16'hd000, 8'hd0); // other sector kept
        done("sector");
        unl(4'h8); // any upper nibble from 8
        wr(16'h8555, CMD_PROG);
        wr(16'he500, 8'h3f); // erased location in range
        t0 = $time;
        chk(8'(busy), 8'h01); // program busy
        acc(1'b0, 16'he500, 8'h00);
        chk(8'(rd_v[TOGGLE_POS]), 8'h01); // first toggle read is one
        acc(1'b0, 16'he500, 8'h00);
        chk(8'(rd_v[TOGGLE_POS]), 8'h00); // toggles on next read
        cmd(CMD_PROG); // new sequence while busy
        wr(16'h9000, 8'h11);
        idle(PROG_CYC); // program time, counted from t0 across the reads and writes above
        rdc(16'he500, 8'h3f); // byte stored
        rdc(16'h9000, 8'h90); // refused write lost
        done("program");
        cmd(CMD_ERASE); // chip erase
        unl(4'hf);
        wr(16'hf555, CMD_CHIP);
        t0 = $time;
        idle(ERASE_SIM); // erase time
        rdc(16'he500, ERASED_BYTE); // all erased
        rdc(16'hd000, ERASED_BYTE); // all erased
        done("chip");
        cmd(CMD_SECURE); // security program
        wr(ADDR_SECURE, SECURE_DATA);
        t0 = $time;
        chk(8'(arr.secure), 8'h01); // array told to secure
        idle(PROG_CYC); // busy time
        tick;
        chk(8'(sec), 8'h01); // secured flag
        cmd(CMD_ID_ENTRY); // id entry
        tick;
        chk(8'(idm), 8'h01); // id mode on
        rdc(ADDR_VENDOR, VID); // vendor code
        rdc(ADDR_FLASH_ID, FID); // flash code
        rdc(ADDR_SECURE, SECURED_BYTE); // security status
        wr(16'h8123, CMD_ID_EXIT); // exit at any flash address
        tick;
        chk(8'(idm), 8'h00); // id mode off
        rdc(ADDR_SECURE, ERASED_BYTE); // array reads again
        done("id");
        pulse(0, 2'b01); // write from flash code
        chk(8'(flash_standby_bit), 8'h00); // discarded
        ram = 1'b1;
        pulse(0, 2'b01); // write from ram code
        chk(8'(flash_standby_bit), 8'h01); // accepted
        acc(1'b0, 16'h8001, 8'h00);
        chk(8'(sr), 8'h01); // access in standby resets
        pulse(1, 2'b01); // ram vector interrupt
        chk(8'(flash_standby_bit), 8'h01); // bit kept
        pulse(1, 2'b00); // flash vector interrupt
        chk(8'(flash_standby_bit), 8'h00); // bit cleared
        rdc(16'h8001, ERASED_BYTE); // flash usable again
        done("standby");
        sprom = 1'b1;
        rst;
        chk(8'({pen, sen}), 8'h00); // inputs gated off
        pulse(2, 2'b10); // clock pin enable
        chk(8'({pen, sen}), 8'h01); // only clock pin open
        pulse(2, 2'b01); // other ports enable
        chk(8'({pen, sen}), 8'h02); // only other ports open
        done("serial");
        conclude;
    end
endmodule
